//--- test_three_phase_pwm_controller.sv
// Self-checking bench for the three-phase PWM block.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("FAIL %0t got %0h exp %0h", $time, (a), (b)); end end
module test_three_phase_pwm_controller;
  import tpp_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, trip_in_n, shoot, sync, sirq, dirq, err, s;
  logic fault_req = 1'b0;
  logic [5:0] g;
  logic [31:0] rd;
  int n_fail = 0;
  int checked = 0;
  int cnt[6];
  int per, wid, nirq;

  always #25 core_clk = ~core_clk;

  tpp_pwm dut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .trip_in_n(trip_in_n),
    .phase_a_high_out(g[0]),
    .phase_a_low_out(g[1]),
    .phase_b_high_out(g[2]),
    .phase_b_low_out(g[3]),
    .phase_c_high_out(g[4]),
    .phase_c_low_out(g[5]),
    .period_sync_pulse(sync),
    .sync_irq(sirq),
    .shutdown_irq(dirq)
  );

  tpp_gate_model drv (
    .core_clk(core_clk),
    .a_hi(g[0]),
    .a_lo(g[1]),
    .b_hi(g[2]),
    .b_lo(g[3]),
    .c_hi(g[4]),
    .c_lo(g[5]),
    .fault_req(fault_req),
    .trip_in_n(trip_in_n),
    .shoot_through(shoot)
  );

  function automatic int on(input int x);
    return x < 0 ? 0 : 2 * x;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k++ < 16) @(posedge core_clk);
    if (k > 16) begin
      n_fail++;
      $display("FAIL %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Measures from one sync rise to the next, counting sync interrupts on the way.
  task automatic sync_meas();
    int k;
    k = 0;
    wid = 0;
    nirq = 0;
    while (sync !== 1'b0 && k++ < 300) @(posedge core_clk);
    while (sync !== 1'b1 && k++ < 600) @(posedge core_clk);
    while (sync === 1'b1 && wid < 300) begin
      nirq += sirq;
      wid++;
      @(posedge core_clk);
    end
    per = wid;
    while (sync !== 1'b1 && per < 600) begin
      nirq += sirq;
      per++;
      @(posedge core_clk);
    end
  endtask

  task automatic count(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge core_clk);
      `CHK($isunknown(g), 1'b0)
      foreach (cnt[i]) cnt[i] += g[i];
    end
  endtask

  // New settings only land at a sync start, so a trip and restart forces one at once.
  task automatic cfg(input logic [31:0] seg, input logic [31:0] gate, input logic [31:0] mp);
    apb(1, OFS_HALF_PERIOD, 32'd10);
    apb(1, OFS_DEAD_TIME, 32'd2);
    apb(1, OFS_MIN_PULSE, mp);
    apb(1, OFS_DUTY_A, 32'd7);
    apb(1, OFS_DUTY_B, 32'd4);
    apb(1, OFS_DUTY_C, 32'd10);
    apb(1, OFS_SEGMENT, seg);
    apb(1, OFS_GATE, gate);
    apb(1, OFS_SYNC_WIDTH, 32'd2);
    apb(1, OFS_SW_TRIP, 32'd0);
    apb(1, OFS_RESTART, 32'd0);
    sync_meas();
    sync_meas();
  endtask

  task automatic t_regs();
    apb(0, OFS_SYNC_WIDTH, 0);
    `CHK(rd, 32'h27)
    apb(0, OFS_MODE, 0);
    `CHK(rd[MODE_DOUBLE_BIT], 1'b0)
    apb(1, OFS_HALF_PERIOD, 32'hffffffff);
    apb(0, OFS_HALF_PERIOD, 0);
    `CHK(rd, 32'hffff)
    apb(1, OFS_DEAD_TIME, 32'hffffffff);
    apb(0, OFS_DEAD_TIME, 0);
    `CHK(rd, 32'h3ff)
    apb(0, 8'h34, 0);
    `CHK({err, rd}, 33'h100000000)
    apb(0, 8'h06, 0);
    `CHK(err, 1'b1)
  endtask

  task automatic t_sync();
    cfg(32'h3f, 32'h0, 32'h0);
    sync_meas();
    `CHK(per, 20)
    `CHK(wid, 3)
    `CHK(nirq, 1)
    apb(1, OFS_MODE, 32'h40);
    sync_meas();
    sync_meas();
    `CHK(per, 10)
    apb(0, OFS_STATUS, 0);
    s = rd[STAT_HALF_BIT];
    // Seven idle edges put the second read exactly one half period after the first.
    repeat (7) @(posedge core_clk);
    apb(0, OFS_STATUS, 0);
    `CHK(rd[STAT_HALF_BIT] ^ s, 1'b1)
    apb(1, OFS_MODE, 32'h0);
  endtask

  task automatic t_wave();
    cfg(32'h3f, 32'h0, 32'h0);
    count(20);
    `CHK(cnt[0], on(7 - 2))
    `CHK(cnt[1], on(10 - 7 - 2))
    `CHK(cnt[2], on(4 - 2))
    `CHK(cnt[3], on(10 - 4 - 2))
    `CHK(cnt[4], on(10 - 2))
    `CHK(cnt[5], on(10 - 10 - 2))
    `CHK(shoot, 1'b0)
    cfg(32'h77, 32'h0, 32'h3);
    count(20);
    `CHK(cnt[0], 0)
    `CHK(cnt[1], on(7 - 2))
    `CHK(cnt[2], on(4 - 2))
    `CHK(cnt[3], 0)
    // A divider of one makes the chop clock run at a quarter of the base rate.
    cfg(32'h3f, 32'h101, 32'h0);
    count(20);
    `CHK(cnt[0] > 0 && cnt[0] < 10, 1'b1)
    `CHK(cnt[1], 2)
    cfg(32'h3f, 32'h200, 32'h0);
    count(20);
    `CHK(cnt[0], 10)
    `CHK(cnt[3] < 8, 1'b1)
  endtask

  task automatic t_trip();
    cfg(32'h3f, 32'h0, 32'h0);
    @(posedge core_clk);
    fault_req <= 1'b1;
    #1;
    `CHK(g, 6'h00)
    // The pin interrupt follows three edges later, behind the synchroniser.
    nirq = 0;
    repeat (6) begin
      @(posedge core_clk);
      nirq += dirq;
    end
    `CHK(nirq, 1)
    apb(1, OFS_RESTART, 0);
    apb(0, OFS_STATUS, 0);
    `CHK(rd[1:0], 2'b10)
    fault_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    apb(1, OFS_RESTART, 0);
    sync_meas();
    count(20);
    `CHK(cnt[0], 10)
    apb(1, OFS_SW_TRIP, 0);
    nirq = 0;
    repeat (4) begin
      @(posedge core_clk);
      nirq += dirq;
    end
    `CHK(nirq, 1)
    `CHK(g, 6'h00)
    apb(0, OFS_STATUS, 0);
    `CHK(rd[STAT_SHUT_BIT], 1'b1)
    `CHK(shoot, 1'b0)
  endtask

  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_sync();
    t_wave();
    t_trip();
    summarize();
  end

  // The whole sequence needs under a thousand cycles; this allows some tens of thousands.
  initial begin
    #3_000_000;
    $display("FAIL %0t watchdog expired", $time);
    n_fail++;
    summarize();
  end
endmodule

//--- tpp_gate_model.sv
// Gate driver stand-in: presents the trip line and watches each leg for shoot-through.
`timescale 1ns/10ps
module tpp_gate_model (
  input wire logic core_clk,
  input wire logic a_hi,
  input wire logic a_lo,
  input wire logic b_hi,
  input wire logic b_lo,
  input wire logic c_hi,
  input wire logic c_lo,
  input wire logic fault_req,
  output logic trip_in_n,
  output logic shoot_through
);
  // The trip line has a pull-up; the driver only ever pulls it low on a fault.
  assign trip_in_n = fault_req ? 1'b0 : 1'b1;
  logic shoot_q = 1'b0;
  // Both switches of one leg on would short the link, so it is latched for the bench.
  always @(posedge core_clk) begin
    if ((a_hi & a_lo) | (b_hi & b_lo) | (c_hi & c_lo)) begin
      shoot_q <= 1'b1;
    end
  end
  assign shoot_through = shoot_q;
endmodule

//--- tpp_pkg.sv
// Package of register map, field layout and reset values for the three-phase PWM block.
package tpp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam logic [7:0] OFS_HALF_PERIOD = 8'h00;
  localparam logic [7:0] OFS_DEAD_TIME = 8'h04;
  localparam logic [7:0] OFS_MIN_PULSE = 8'h08;
  localparam logic [7:0] OFS_DUTY_A = 8'h0c;
  localparam logic [7:0] OFS_DUTY_B = 8'h10;
  localparam logic [7:0] OFS_DUTY_C = 8'h14;
  localparam logic [7:0] OFS_SEGMENT = 8'h18;
  localparam logic [7:0] OFS_GATE = 8'h1c;
  localparam logic [7:0] OFS_MODE = 8'h20;
  localparam logic [7:0] OFS_SYNC_WIDTH = 8'h24;
  localparam logic [7:0] OFS_SW_TRIP = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_RESTART = 8'h30;
  localparam int SEG_XOVER_LSB = 6;
  localparam int GATE_HI_CHOP_BIT = 8;
  localparam int GATE_LO_CHOP_BIT = 9;
  localparam int MODE_DOUBLE_BIT = 6;
  localparam int STAT_TRIP_BIT = 0;
  localparam int STAT_SHUT_BIT = 1;
  localparam int STAT_HALF_BIT = 3;
  localparam logic [15:0] HALF_PERIOD_RST = 16'h0000;
  localparam logic [9:0] DEAD_TIME_RST = 10'h000;
  localparam logic [15:0] MIN_PULSE_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [8:0] SEGMENT_RST = 9'h000;
  localparam logic [9:0] GATE_RST = 10'h000;
  localparam logic [7:0] SYNC_WIDTH_RST = 8'h27;
  typedef enum logic [0:0] {
    TPP_FIRST = 1'b0,
    TPP_SECOND = 1'b1
  } tpp_half_t;
endpackage

//--- tpp_pwm.sv
// Three-phase center-based PWM generator with APB register access.
//
// Notes on behaviour
// (R1) Three phase pairs of active-high high-side and low-side outputs, six in all.
// (R2) Base unit is one clock; switching period is twice the half-period count.
// (R3) Half-period is a 16-bit register accepting values up to 0xFFFF.
// (R4) All PWM logic runs on the instruction-rate clock.
// (R5) Frequency, dead time and minimum pulse come from three separate registers.
// (R6) Three 16-bit duty registers, one per phase.
// (R7) Each phase yields a complementary center-based pair with dead-time-shifted edges.
// (R8) Each of the six outputs has its own enable bit in the segment register.
// (R9) A set crossover bit swaps high and low waveforms of that phase.
// (R10) Outputs are mixed with a chopping signal whose rate is an 8-bit field.
// (R11) Chopping is enabled separately for high-side and low-side outputs.
// (R12) Single update mode takes new duty values once per period.
// (R13) Double update mode also takes new values at the period midpoint.
// (R14) Mode bit 6 selects single (clear) or double (set) update.
// (R15) Sync pulse at each period start, and at midpoint in double mode.
// (R16) Sync pulse width is programmable by its own register.
// (R17) Trip pin low forces all outputs low through unclocked logic.
// (R18) A write to the software trip register shuts all outputs down.
// (R19) Shutdown control handles pin and software trips and holds the timing unit.
// (R20) Status shows the trip pin level and the half-period indicator.
// (R21) One interrupt per sync pulse and one on any shutdown event.
// (R22) Dead time between complements is twice the 10-bit register; zero means none.
// (R23) Sync pulse lasts width register plus one; that register resets to 0x27.
// (R24) Each sync start loads settings, duty values and segment into working copies.
// (R25) Status bit 3 reads zero in the first half, one in the second.
// (R26) Duty is compared against a center-based count to set high-side on-time.
`timescale 1ns/10ps
module tpp_pwm (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [tpp_pkg::DATA_W-1:0] pwdata,
  output logic [tpp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trip_in_n,
  output logic phase_a_high_out,
  output logic phase_a_low_out,
  output logic phase_b_high_out,
  output logic phase_b_low_out,
  output logic phase_c_high_out,
  output logic phase_c_low_out,
  output logic period_sync_pulse,
  output logic sync_irq,
  output logic shutdown_irq
);
  import tpp_pkg::*;

  logic [15:0] half_period_q;
  logic [9:0] dead_time_q;
  logic [15:0] min_pulse_q;
  logic [15:0] duty_q [3];
  logic [8:0] seg_q;
  logic [9:0] gate_q;
  logic mode_dbl_q;
  logic [7:0] sync_width_q;
  logic [15:0] tm_w;
  logic [9:0] dt_w;
  logic [15:0] pd_w;
  logic [7:0] sw_w;
  logic [15:0] duty_w [3];
  logic [8:0] seg_w;
  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic trip_s1_q;
  logic trip_s2_q;
  logic sd_q;
  logic sd_irq_q;
  logic init_q;
  logic [15:0] pos_q;
  tpp_half_t half_q;
  logic sync_q;
  logic [7:0] scnt_q;
  logic sync_irq_q;
  logic [7:0] chop_cnt_q;
  logic chop_q;
  logic [5:0] out_q;
  logic [5:0] out_d;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= OFS_RESTART) && (a[1:0] == 2'b00);
  endfunction

  // Zero-wait slave: read data and error are prepared in the setup cycle.
  wire setup_w = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite;
  wire wr_half = wr_en && (paddr == OFS_HALF_PERIOD);
  wire wr_dead = wr_en && (paddr == OFS_DEAD_TIME);
  wire wr_pulse = wr_en && (paddr == OFS_MIN_PULSE);
  wire wr_da = wr_en && (paddr == OFS_DUTY_A);
  wire wr_db = wr_en && (paddr == OFS_DUTY_B);
  wire wr_dc = wr_en && (paddr == OFS_DUTY_C);
  wire wr_seg = wr_en && (paddr == OFS_SEGMENT);
  wire wr_gate = wr_en && (paddr == OFS_GATE);
  wire wr_mode = wr_en && (paddr == OFS_MODE);
  wire wr_swidth = wr_en && (paddr == OFS_SYNC_WIDTH);
  wire sw_trip_w = wr_en && (paddr == OFS_SW_TRIP);
  wire restart_w = wr_en && (paddr == OFS_RESTART);

  wire [31:0] status_w = {28'h0000000, half_q == TPP_SECOND, 1'b0, sd_q, trip_s2_q};
  wire [31:0] rd_w =
    (paddr == OFS_HALF_PERIOD) ? {16'h0000, half_period_q} :
    (paddr == OFS_DEAD_TIME) ? {22'h000000, dead_time_q} :
    (paddr == OFS_MIN_PULSE) ? {16'h0000, min_pulse_q} :
    (paddr == OFS_DUTY_A) ? {16'h0000, duty_q[0]} :
    (paddr == OFS_DUTY_B) ? {16'h0000, duty_q[1]} :
    (paddr == OFS_DUTY_C) ? {16'h0000, duty_q[2]} :
    (paddr == OFS_SEGMENT) ? {23'h000000, seg_q} :
    (paddr == OFS_GATE) ? {22'h000000, gate_q} :
    (paddr == OFS_MODE) ? {25'h0000000, mode_dbl_q, 6'h00} :
    (paddr == OFS_SYNC_WIDTH) ? {24'h000000, sync_width_q} :
    (paddr == OFS_STATUS) ? status_w : 32'h00000000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_w;
      if (setup_w) begin
        prdata_q <= rd_w;
        pslverr_q <= ~is_mapped(paddr);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_period_q <= HALF_PERIOD_RST;
      dead_time_q <= DEAD_TIME_RST;
      min_pulse_q <= MIN_PULSE_RST;
      duty_q[0] <= DUTY_RST;
      duty_q[1] <= DUTY_RST;
      duty_q[2] <= DUTY_RST;
      seg_q <= SEGMENT_RST;
      gate_q <= GATE_RST;
      mode_dbl_q <= 1'b0;
      sync_width_q <= SYNC_WIDTH_RST; // see (R23)
    end else begin
      if (wr_half) half_period_q <= pwdata[15:0]; // see (R3)
      if (wr_dead) dead_time_q <= pwdata[9:0]; // see (R5)
      if (wr_pulse) min_pulse_q <= pwdata[15:0];
      if (wr_da) duty_q[0] <= pwdata[15:0]; // see (R6)
      if (wr_db) duty_q[1] <= pwdata[15:0];
      if (wr_dc) duty_q[2] <= pwdata[15:0];
      if (wr_seg) seg_q <= pwdata[8:0];
      if (wr_gate) gate_q <= pwdata[9:0];
      if (wr_mode) mode_dbl_q <= pwdata[MODE_DOUBLE_BIT]; // see (R14)
      if (wr_swidth) sync_width_q <= pwdata[7:0]; // see (R16)
    end
  end

  // For status and latching the pin is read only through these two flops.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trip_s1_q <= 1'b1;
      trip_s2_q <= 1'b1;
    end else begin
      trip_s1_q <= trip_in_n;
      trip_s2_q <= trip_s1_q; // see (R20)
    end
  end

  // Shutdown stays latched until software restarts with the pin released.
  wire sd_set = ~trip_s2_q | sw_trip_w;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sd_q <= 1'b0;
      sd_irq_q <= 1'b0;
    end else begin
      if (sd_set) sd_q <= 1'b1; // see (R18) (R19)
      else if (restart_w) sd_q <= 1'b0;
      sd_irq_q <= sd_set & ~sd_q; // see (R21)
    end
  end

  wire [15:0] last_w = tm_w - 16'h0001;
  wire wrap_w = (pos_q == last_w);
  wire st_w = ~sd_q & (init_q | (wrap_w & ((half_q == TPP_SECOND) | mode_dbl_q))); // see (R15)

  // Timing unit counts base units through two halves of the period.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= 16'h0000;
      half_q <= TPP_FIRST;
      init_q <= 1'b1;
    end else if (sd_q) begin
      pos_q <= 16'h0000; // see (R19)
      half_q <= TPP_FIRST;
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
      if (init_q) begin
        pos_q <= 16'h0000;
        half_q <= TPP_FIRST;
      end else if (wrap_w) begin
        pos_q <= 16'h0000; // see (R2)
        half_q <= (half_q == TPP_FIRST) ? TPP_SECOND : TPP_FIRST; // see (R25)
      end else begin
        pos_q <= pos_q + 16'h0001;
      end
    end
  end

  // Working copies change only at sync starts, so software may write at any time.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tm_w <= HALF_PERIOD_RST;
      dt_w <= DEAD_TIME_RST;
      pd_w <= MIN_PULSE_RST;
      sw_w <= SYNC_WIDTH_RST;
      duty_w[0] <= DUTY_RST;
      duty_w[1] <= DUTY_RST;
      duty_w[2] <= DUTY_RST;
      seg_w <= SEGMENT_RST;
    end else if (st_w) begin
      tm_w <= half_period_q; // see (R24) (R12) (R13)
      dt_w <= dead_time_q;
      pd_w <= min_pulse_q;
      sw_w <= sync_width_q;
      duty_w[0] <= duty_q[0];
      duty_w[1] <= duty_q[1];
      duty_w[2] <= duty_q[2];
      seg_w <= seg_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 1'b0;
      scnt_q <= 8'h00;
      sync_irq_q <= 1'b0;
    end else begin
      sync_irq_q <= st_w; // see (R21)
      // A shutdown cuts a running sync pulse short, as the whole timing unit is held.
      if (sd_q) begin
        sync_q <= 1'b0; // see (R19)
      end else if (st_w) begin
        sync_q <= 1'b1; // see (R15)
        scnt_q <= sync_width_q; // see (R23)
      end else if (sync_q) begin
        if (scnt_q == 8'h00) sync_q <= 1'b0;
        else scnt_q <= scnt_q - 8'h01;
      end
    end
  end

  // Chopping clock toggles every (field + 1) base units.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chop_cnt_q <= 8'h00;
      chop_q <= 1'b0;
    end else if (chop_cnt_q >= gate_q[7:0]) begin
      chop_cnt_q <= 8'h00; // see (R10)
      chop_q <= ~chop_q;
    end else begin
      chop_cnt_q <= chop_cnt_q + 8'h01;
    end
  end

  wire [17:0] pos18 = {2'b00, pos_q};
  wire [17:0] tm18 = {2'b00, tm_w};
  wire [17:0] dt18 = {8'h00, dt_w};
  wire [17:0] pd18 = {2'b00, pd_w};
  wire second_w = (half_q == TPP_SECOND);
  wire hi_chop_w = ~gate_q[GATE_HI_CHOP_BIT] | chop_q;
  wire lo_chop_w = ~gate_q[GATE_LO_CHOP_BIT] | chop_q;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_phase
      wire [17:0] d18 = {2'b00, duty_w[p]};
      // High side is centered on the period midpoint; each edge moves by the dead time.
      wire hi_first = (pos18 + d18) >= (tm18 + dt18); // see (R26) (R7)
      wire hi_sec = (pos18 + dt18) < d18;
      wire lo_first = (pos18 + d18 + dt18) < tm18; // see (R22)
      wire lo_sec = pos18 >= (d18 + dt18);
      wire [17:0] hon = (d18 > dt18) ? (d18 - dt18) : 18'h00000;
      wire [17:0] lon = (tm18 > (d18 + dt18)) ? (tm18 - d18 - dt18) : 18'h00000;
      // Pulses shorter than the minimum width are deleted rather than shortened.
      wire hi_w = (second_w ? hi_sec : hi_first) & ({hon[16:0], 1'b0} >= pd18); // see (R5)
      wire lo_w = (second_w ? lo_sec : lo_first) & ({lon[16:0], 1'b0} >= pd18);
      wire xo = seg_w[SEG_XOVER_LSB + p];
      wire hs = xo ? lo_w : hi_w; // see (R9)
      wire ls = xo ? hi_w : lo_w;
      assign out_d[2*p] = hs & seg_w[2*p] & hi_chop_w & ~sd_q & ~init_q; // see (R8) (R11)
      assign out_d[2*p+1] = ls & seg_w[2*p+1] & lo_chop_w & ~sd_q & ~init_q;
    end
  endgenerate

  // The raw pin clears the output flops with no clock involved, so a stopped
  // clock cannot keep a gate on; the glitch risk is accepted for safety.
  wire out_rst_n = arst_n & trip_in_n; // see (R17)
  always_ff @(posedge core_clk or negedge out_rst_n) begin
    if (!out_rst_n) out_q <= 6'h00;
    else out_q <= out_d; // see (R4)
  end

  assign phase_a_high_out = out_q[0]; // see (R1)
  assign phase_a_low_out = out_q[1];
  assign phase_b_high_out = out_q[2];
  assign phase_b_low_out = out_q[3];
  assign phase_c_high_out = out_q[4];
  assign phase_c_low_out = out_q[5];
  assign period_sync_pulse = sync_q;
  assign sync_irq = sync_irq_q;
  assign shutdown_irq = sd_irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  logic [8:0] slen_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) slen_q <= 9'h000;
    else if (st_w) slen_q <= 9'h000;
    else if (sync_q) slen_q <= slen_q + 9'h001;
  end

  trip_low_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R17)
    !trip_in_n |-> out_q == 6'h00) else $error("outputs high while trip pin low");
  sw_trip_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R18)
    sw_trip_w |=> sd_q ##1 out_q == 6'h00) else $error("software trip did not stop outputs");
  hold_timer_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R19)
    sd_q |=> pos_q == 16'h0000 && !sync_q) else $error("timer runs during shutdown");
  sync_len_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R23)
    $fell(sync_q) && !$past(st_w) && !$past(sd_q) |-> slen_q == {1'b0, sw_w} + 9'h001)
    else $error("sync pulse width wrong");
  mid_sync_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R13)
    wrap_w && !sd_q && !init_q && half_q == TPP_FIRST && mode_dbl_q |=> sync_q && sync_irq)
    else $error("missing midpoint sync");
  single_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R12)
    wrap_w && !init_q && half_q == TPP_FIRST && !mode_dbl_q |=> $stable(duty_w[0]))
    else $error("duty changed at midpoint in single mode");
  half_stat_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R25)
    setup_w && paddr == OFS_STATUS |=> prdata_q[STAT_HALF_BIT] == $past(second_w))
    else $error("half indicator misreported");
  no_overlap_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R22)
    !(out_q[0] && out_q[1]) && !(out_q[2] && out_q[3]) && !(out_q[4] && out_q[5]))
    else $error("both switches of a pair on");
  enable_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R8)
    !seg_w[0] && !st_w |=> !out_q[0]) else $error("disabled output drove high");
  latch_sync_a: assert property (@(posedge core_clk) disable iff (!arst_n) // see (R24)
    st_w |=> tm_w == $past(half_period_q) && seg_w == $past(seg_q))
    else $error("settings not loaded at sync");
endmodule
